// ==== core/pba_core.sv ====
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/100ps
// Summary of operation
// - Value bytes ignored while control bytes are zero or during a read.
// - Successful read returns status 01F1xxx0, flag clear, value in bytes.
// - Failed read sets bit 5 of status 1 and returns error code.
// - Value words travel least significant byte first, both directions.
// - Write response has status bit 0 set; read response has it clear.
// - Parameter 0xA8 holds writable projected slave mask steering the master.
// - Parameter 0xB0 returns the detected slave mask.
// - Process image size comes up at 24 bytes until reconfigured.
// - Failed write sets the error flag and returns an error code.
module pba_core (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] detected_slave_in,
  output logic [31:0] projected_slave_mask,
  output logic [7:0] image_size
);
  logic [7:0] ctrl0_r;
  logic [7:0] ctrl1_r;
  logic [31:0] req_value_r;
  logic [7:0] stat0_r;
  logic [7:0] stat1_r;
  logic [31:0] resp_value_r;
  logic [31:0] det_s1_r;
  logic [31:0] det_s2_r;
  logic [31:0] projected_r;
  logic [7:0] image_r;
  pba_pkg::pba_state_t state_r;
  logic [31:0] prdata_r;
  logic ctrl_zero;
  logic req_valid;
  logic is_write;
  logic [9:0] req_addr;
  logic apb_wr;
  logic apb_rd;
  logic known;
  logic take_req;
  logic release_req;
  logic hit_projected;
  logic hit_detected;
  logic hit_image;
  logic req_error;
  logic [31:0] req_result;

  function automatic logic [31:0] pack_bytes(input logic [7:0] b0, input logic [7:0] b1,
                                             input logic [7:0] b2, input logic [7:0] b3);
    pack_bytes = {b3, b2, b1, b0};
  endfunction : pack_bytes

  function automatic logic [7:0] status_byte(input logic err, input logic wr);
    status_byte = {pba_pkg::STAT1_BUSY_HI, 4'h0};
    status_byte[pba_pkg::STAT1_ERR_BIT] = err;
    status_byte[pba_pkg::STAT1_WR_BIT] = wr;
  endfunction : status_byte

  assign ctrl_zero = (ctrl0_r == 8'h00) && (ctrl1_r == 8'h00);
  assign is_write = (ctrl0_r[7:6] == pba_pkg::OP_WRITE);
  assign req_valid = (ctrl1_r[7:4] == pba_pkg::CTRL1_TAG) &&
                     ((ctrl0_r[7:6] == pba_pkg::OP_READ) || is_write);
  assign req_addr = {ctrl1_r[3:0], ctrl0_r[5:0]};
  assign apb_wr = psel && penable && pwrite;
  // Read data is captured in the setup cycle, so this marks the setup of a read
  assign apb_rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign known = (paddr[1:0] == 2'h0) && (paddr <= pba_pkg::APB_IMAGE);
  assign pslverr = psel && penable && !known;
  assign prdata = prdata_r;
  assign projected_slave_mask = projected_r;
  assign image_size = image_r;

  // A request is taken once, from idle; the value bytes matter only then
  assign take_req = (state_r == pba_pkg::ST_IDLE) && !ctrl_zero && req_valid;
  assign release_req = (state_r == pba_pkg::ST_DONE) && ctrl_zero;
  assign hit_projected = (req_addr == pba_pkg::PAR_PROJECTED);
  assign hit_detected = (req_addr == pba_pkg::PAR_DETECTED);
  assign hit_image = (req_addr == pba_pkg::PAR_IMAGE_SIZE);

  // Host side of the process image
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ctrl0_r <= 8'h00;
      ctrl1_r <= 8'h00;
    end else if (apb_wr && paddr == pba_pkg::APB_CTRL) begin
      ctrl0_r <= pwdata[7:0];
      ctrl1_r <= pwdata[15:8];
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      req_value_r <= 32'h00000000;
    end else if (apb_wr && paddr == pba_pkg::APB_VALUE_OUT) begin
      req_value_r <= pack_bytes(pwdata[7:0], pwdata[15:8], pwdata[23:16], pwdata[31:24]);
    end
  end

  // Detection levels come from the link side and pass two flops first
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      det_s1_r <= 32'h00000000;
      det_s2_r <= 32'h00000000;
    end else begin
      det_s1_r <= detected_slave_in;
      det_s2_r <= det_s1_r;
    end
  end

  // Outcome of the request now standing in the control bytes
  always_comb begin
    req_error = 1'b0;
    req_result = 32'h00000000;
    if (hit_projected) begin
      if (!is_write) begin
        req_result = projected_r;
      end
    end else if (hit_detected) begin
      if (is_write) begin
        req_error = 1'b1;
        req_result = pba_pkg::ERR_READ_ONLY;
      end else begin
        req_result = det_s2_r;
      end
    end else if (hit_image) begin
      if (!is_write) begin
        req_result = {24'h000000, image_r};
      end else if (req_value_r[31:8] != 24'h000000) begin
        req_error = 1'b1;
        req_result = pba_pkg::ERR_BAD_VALUE;
      end
    end else begin
      req_error = 1'b1;
      req_result = pba_pkg::ERR_BAD_ADDR;
    end
  end

  // Parameter engine: one access in flight until the host zeroes the control bytes
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_r <= pba_pkg::ST_IDLE;
    end else begin
      case (state_r)
        pba_pkg::ST_IDLE: begin
          if (take_req) begin
            state_r <= pba_pkg::ST_DONE;
          end
        end
        pba_pkg::ST_DONE: begin
          if (release_req) begin
            state_r <= pba_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= pba_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Status bytes stay put while the response stands
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      stat0_r <= 8'h00;
      stat1_r <= 8'h00;
    end else if (take_req) begin
      stat1_r <= status_byte(req_error, is_write);
    end else if (release_req) begin
      stat1_r <= 8'h00;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      resp_value_r <= 32'h00000000;
    end else if (take_req) begin
      resp_value_r <= req_result;
    end
  end

  // Settings change only on a successful write request
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      projected_r <= 32'h00000000;
    end else if (take_req && is_write && hit_projected) begin
      projected_r <= req_value_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      image_r <= pba_pkg::IMAGE_SIZE_RST;
    end else if (take_req && is_write && hit_image && !req_error) begin
      image_r <= req_value_r[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      prdata_r <= 32'h00000000;
    end else if (apb_rd) begin
      case (paddr)
        pba_pkg::APB_CTRL: prdata_r <= {16'h0000, ctrl1_r, ctrl0_r};
        pba_pkg::APB_VALUE_OUT: prdata_r <= req_value_r;
        pba_pkg::APB_STATUS: prdata_r <= {16'h0000, stat1_r, stat0_r};
        pba_pkg::APB_VALUE_IN: prdata_r <= resp_value_r;
        pba_pkg::APB_DETECT: prdata_r <= det_s2_r;
        pba_pkg::APB_PROJECT: prdata_r <= projected_r;
        pba_pkg::APB_IMAGE: prdata_r <= {24'h000000, image_r};
        default: prdata_r <= 32'h00000000;
      endcase
    end
  end
endmodule : pba_core

// ==== core/pba_pkg.sv ====
package pba_pkg;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [3:0] CTRL1_TAG = 4'h4;
  localparam logic [3:0] STAT1_BUSY_HI = 4'h5;
  localparam int STAT1_ERR_BIT = 5;
  localparam int STAT1_WR_BIT = 0;
  localparam logic [9:0] PAR_PROJECTED = 10'h0A8;
  localparam logic [9:0] PAR_DETECTED = 10'h0B0;
  localparam logic [9:0] PAR_IMAGE_SIZE = 10'h0B4;
  localparam logic [7:0] IMAGE_SIZE_RST = 8'h18;
  localparam logic [31:0] ERR_BAD_ADDR = 32'h00000002;
  localparam logic [31:0] ERR_READ_ONLY = 32'h00000003;
  localparam logic [31:0] ERR_BAD_VALUE = 32'h00000004;
  localparam logic [11:0] APB_CTRL = 12'h000;
  localparam logic [11:0] APB_VALUE_OUT = 12'h004;
  localparam logic [11:0] APB_STATUS = 12'h008;
  localparam logic [11:0] APB_VALUE_IN = 12'h00C;
  localparam logic [11:0] APB_DETECT = 12'h010;
  localparam logic [11:0] APB_PROJECT = 12'h014;
  localparam logic [11:0] APB_IMAGE = 12'h018;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_DONE = 2'b01} pba_state_t;
endpackage : pba_pkg

// ==== test/parameter_block_access_tb_top.sv ====
`timescale 1ns/100ps
module parameter_block_access_tb_top;
  logic mclk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, detected_slave_in, projected_slave_mask;
  logic [7:0] image_size;
  int fail_count = 0, checks = 0;
  pba_core dut (.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .detected_slave_in, .projected_slave_mask, .image_size);
  pba_node_model u_node (.detected_slave_in);
  initial forever #4 mclk = ~mclk;
  task automatic cmp(string n, logic [31:0] e, g);
    checks++;
    fail_count += (g !== e);
    if (g !== e) $display("[FAIL] %s exp %h got %h", n, e, g);
  endtask : cmp
  // Reads compare against d, writes send it
  task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1);
    if (!w) cmp($sformatf("rd %h", a), d, prdata);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : xfer
  task automatic op(logic [15:0] c, logic [31:0] v, logic [15:0] s, logic [31:0] r);
    xfer(1'h1, pba_pkg::APB_VALUE_OUT, v);
    xfer(1'h1, pba_pkg::APB_CTRL, {16'h0, c});
    xfer(1'h0, pba_pkg::APB_STATUS, {16'h0, s});
    xfer(1'h0, pba_pkg::APB_VALUE_IN, r);
    xfer(1'h1, pba_pkg::APB_CTRL, 32'h0);
    xfer(1'h0, pba_pkg::APB_STATUS, 32'h0);
  endtask : op
  task automatic finish_test(int bump);
    fail_count += bump;
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  initial #20000 finish_test(1);
  initial begin
    repeat (2) @(posedge mclk);
    resetn <= 1'h1;
    xfer(1'h0, pba_pkg::APB_IMAGE, 32'h18);
    cmp("image", 32'h18, {24'h0, image_size});
    op(16'h4268, 32'h4003101E, 16'h5100, 32'h0);
    cmp("projected", 32'h4003101E, projected_slave_mask);
    op(16'h4228, 32'hFFFFFFFF, 16'h5000, 32'h4003101E);
    op(16'h4230, 32'h0, 16'h5000, 32'h8380024C);
    op(16'h4270, 32'h1, 16'h7100, pba_pkg::ERR_READ_ONLY);
    op(16'h4F3F, 32'h0, 16'h7000, pba_pkg::ERR_BAD_ADDR);
    op(16'h4274, 32'hC, 16'h5100, 32'h0);
    xfer(1'h0, pba_pkg::APB_IMAGE, 32'hC);
    cmp("image", 32'hC, {24'h0, image_size});
    xfer(1'h0, pba_pkg::APB_PROJECT, 32'h4003101E);
    xfer(1'h0, 12'h20, 32'h0);
    finish_test(0);
  end
endmodule : parameter_block_access_tb_top
bind pba_core pba_checker u_chk (.mclk, .resetn, .psel, .penable, .pwrite, .pready, .pslverr, .paddr, .prdata,
  .projected_slave_mask, .image_size);

// ==== test/pba_checker.sv ====
`timescale 1ns/100ps
module pba_checker (
  input logic mclk,
  input logic resetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic pready,
  input logic pslverr,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic [31:0] projected_slave_mask,
  input logic [7:0] image_size
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_rd(a); psel && !penable && !pwrite && paddr == a; endsequence
  property p_img; !$past(resetn) |-> image_size == 8'h18; endproperty
  a_img: assert property (p_img) else $error("image size reset");
  property p_proj; s_rd(pba_pkg::APB_PROJECT) |=> prdata == $past(projected_slave_mask); endproperty
  a_proj: assert property (p_proj) else $error("projected read");
  property p_size; s_rd(pba_pkg::APB_IMAGE) |=> prdata == {24'h0, $past(image_size)}; endproperty
  a_size: assert property (p_size) else $error("image read");
  property p_bad; s_rd(12'h020) |=> pslverr && prdata == 32'h0; endproperty
  a_bad: assert property (p_bad) else $error("unmapped read");
  property p_ok; psel && penable && paddr == pba_pkg::APB_STATUS |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("status error");
  property p_rdy; psel && penable |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready low");
  property p_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  // Settings show a new value only two edges after a write access lands
  property p_cfg; !$past(psel && penable && pwrite, 2)
    |-> $stable(projected_slave_mask) && $stable(image_size); endproperty
  a_cfg: assert property (p_cfg) else $error("setting moved");
endmodule : pba_checker

// ==== test/pba_node_model.sv ====
`timescale 1ns/100ps
module pba_node_model (output logic [31:0] detected_slave_in);
  // Nodes 2, 3, 6, 9, 23, 24, 25 and 31 seen on the link
  initial detected_slave_in = 32'h8380024C;
endmodule : pba_node_model
